/* bench/mrf_phy_model.sv */
// Model of the PHY receive side feeding octets to the filter
`timescale 1ns/1ps
module mrf_phy_model (
  // Clock
  input wire logic clk_i,
  // Octets toward the filter
  output logic rx_valid_o,
  output mrf_pkg::mrf_byte_type rx_byte_o,
  output logic rx_crc_ok_o
);
  import mrf_pkg::*;
  logic [7:0] frm [0:127]; // Frame octets, FCS included, filled by the bench
  // Idle lines at power-up
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o = '0;
    rx_crc_ok_o = 1'b0;
  end
  // One frame; a stall after octet 3 so gaps are exercised
  task automatic send(input int n, input logic crc);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_byte_o <= '{sof: k == 0, eof: k == n - 1, data: frm[k]};
      rx_crc_ok_o <= crc;
      if (k == 3) begin
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_byte_o <= ~rx_byte_o;
      end
    end
    // Idle: stale octet inverted so it cannot pass for a real one
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_byte_o <= ~rx_byte_o;
    rx_crc_ok_o <= ~crc;
  endtask
endmodule

/* bench/mrf_rx_checker.sv */
// Port assertions for the rx frame filter
`timescale 1ns/1ps
module mrf_rx_checker (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Watched ports
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic rx_valid_i,
  input wire mrf_pkg::mrf_byte_type rx_byte_i,
  input wire logic rx_crc_ok_i,
  input wire logic out_valid_o,
  input wire mrf_pkg::mrf_byte_type out_byte_o,
  input wire logic out_end_o,
  input wire logic [31:0] out_status_o,
  input wire logic quanta_valid_o
);
  import mrf_pkg::*;
  // One clock domain
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  rd_data_idle_a: assert property (ce_i && !reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data not zero without a read");
  no_octet_out_a: assert property (ce_i && !rx_valid_i |=> !out_valid_o)
    else $error("octet forwarded without input");
  octet_copy_a: assert property (out_valid_o && $past(ce_i)
    |-> out_byte_o == $past(rx_byte_i))
    else $error("forwarded octet differs");
  end_after_eof_a: assert property (ce_i && rx_valid_i && rx_byte_i.eof |=> out_end_o)
    else $error("frame end missing");
  end_has_cause_a: assert property (out_end_o && $past(ce_i)
    |-> $past(rx_valid_i && rx_byte_i.eof))
    else $error("frame end without eof");
  quanta_cause_a: assert property (quanta_valid_o && $past(ce_i)
    |-> out_end_o && out_status_o[9] && $past(rx_crc_ok_i))
    else $error("quanta without good pause frame");
  quanta_len_ok_a: assert property (quanta_valid_o |-> !out_status_o[1])
    else $error("quanta despite length error");
  status_hold_a: assert property (!out_end_o |-> $stable(out_status_o))
    else $error("status moved between frame ends");
endmodule

/* bench/test_mrf_rx_frame_filter.sv */
// Self-checking bench for the rx frame filter
`timescale 1ns/1ps
`include "mrf_defs.svh"
module test_mrf_rx_frame_filter;
  import mrf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1; // Clock enable, dropped only by the freeze scenario
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic rx_valid_i;
  logic rx_crc_ok_i;
  mrf_byte_type rx_byte_i;
  logic out_valid_o;
  logic out_end_o;
  logic quanta_valid_o;
  mrf_byte_type out_byte_o;
  logic [31:0] out_status_o;
  logic [15:0] quanta_o;
  int errors = 0;
  int tests_run = 0;
  int nout; // Octets forwarded in the last frame
  int nq; // Quanta pulses in the last frame
  int cyc = 0; // Cycles since start, for the hang limit
  logic [31:0] st; // Last frame status
  logic [31:0] q; // Last quanta
  logic [31:0] d; // Read data
  logic [63:0] tab; // Bench image of the table
  localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF; // Broadcast
  localparam logic [47:0] MC = 48'h0300_0100_0007; // Multicast, asymmetric hashes
  // Filter under test
  mrf_rx_frame_filter i_mrf_rx_frame_filter (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rx_valid_i(rx_valid_i),
    .rx_byte_i(rx_byte_i), .rx_crc_ok_i(rx_crc_ok_i), .out_valid_o(out_valid_o),
    .out_byte_o(out_byte_o), .out_end_o(out_end_o), .out_status_o(out_status_o),
    .quanta_valid_o(quanta_valid_o), .quanta_o(quanta_o));
  mrf_phy_model i_mrf_phy_model (.clk_i(clk_i), .rx_valid_o(rx_valid_i),
    .rx_byte_o(rx_byte_i), .rx_crc_ok_o(rx_crc_ok_i));
  // Clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // Watches outputs; sampled before the edge's updates land
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (out_valid_o === 1'b1) nout++;
    if (out_end_o === 1'b1) st = out_status_o;
    if (quanta_valid_o === 1'b1) begin
      nq++;
      q = {16'h0, quanta_o};
    end
    // Hang limit, well above the roughly 1200 cycles needed
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // Hash code worked out independently of the design
  function automatic logic [5:0] hsh(input logic [47:0] a, input logic sel);
    for (int i = 0; i < 6; i++) hsh[i] = sel ? ^a[4*i +: 4] : ^a[8*i +: 8];
  endfunction
  // Builds a frame: DA, unicast SA, type, eight header octets, zero pad and FCS
  task automatic frm(input logic [47:0] da, input logic [15:0] t, input logic [63:0] h,
    input int n, input logic crc);
    for (int k = 0; k < 128; k++) i_mrf_phy_model.frm[k] = 8'h00;
    for (int k = 0; k < 6; k++) begin
      i_mrf_phy_model.frm[k] = da[8*k +: 8];
      i_mrf_phy_model.frm[6+k] = 8'h20 + 8'(k);
    end
    i_mrf_phy_model.frm[12] = t[15:8];
    i_mrf_phy_model.frm[13] = t[7:0];
    for (int k = 0; k < 8; k++) i_mrf_phy_model.frm[14+k] = h[63-8*k -: 8];
    nout = 0;
    nq = 0;
    i_mrf_phy_model.send(n, crc);
    repeat (3) @(posedge clk_i);
  endtask
  // Reset values, write/read back, unmapped place
  task automatic t_regs();
    rd(`MRF_OFF_HASH_LO);
    check(d, 32'h0);
    rd(`MRF_OFF_HASH_HI);
    check(d, 32'h0);
    wr(`MRF_OFF_HASH_HI, 32'hA5C3_0F01);
    rd(`MRF_OFF_HASH_HI);
    check(d, 32'hA5C3_0F01);
    wr(`MRF_OFF_HASH_HI, 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20);
    check(d, 32'h0);
  endtask
  // Multicast hashing in both source modes, broadcast
  task automatic t_mcast();
    frm(MC, 16'h0800, 64'h0, 64, 1'b1);
    check(st[8], 32'h1);
    frm(BC, 16'h0800, 64'h0, 64, 1'b1);
    check(st[8], 32'h0);
    tab = 64'h1 << hsh(MC, 1'b0);
    wr(`MRF_OFF_HASH_LO, tab[31:0]);
    wr(`MRF_OFF_HASH_HI, tab[63:32]);
    frm(MC, 16'h0800, 64'h0, 64, 1'b1);
    check(st[8], 32'h0);
    wr(`MRF_OFF_CONFIG, 32'h1);
    frm(MC, 16'h0800, 64'h0, 64, 1'b1);
    check(st[8], {31'h0, !tab[hsh(MC, 1'b1)]});
    wr(`MRF_OFF_HASH_LO, 32'hFFFF_FFFF);
    wr(`MRF_OFF_HASH_HI, 32'hFFFF_FFFF);
    frm(MC, 16'h0800, 64'h0, 64, 1'b1);
    check(st[8], 32'h0);
  endtask
  // Enable low: a table write must not land
  task automatic t_freeze();
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(`MRF_OFF_HASH_LO, 32'h0000_0F0F);
    ce_i <= 1'b1;
    rd(`MRF_OFF_HASH_LO);
    check(d, 32'hFFFF_FFFF);
  endtask
  // Length check, tags and pad removal
  task automatic t_len();
    wr(`MRF_OFF_CONFIG, 32'h2);
    frm(BC, 16'h0010, 64'h0, 64, 1'b1);
    check(nout, 30);
    check(st[1], 32'h0);
    frm(BC, 16'h0010, 64'h0, 70, 1'b1);
    check(st[1], 32'h1);
    frm(BC, 16'h8100, {16'h0005, 16'h0010, 32'h0}, 64, 1'b1);
    check(nout, 34);
    check(st[17:16], 32'h1);
    frm(BC, 16'h8100, {16'h0005, 16'h8100, 16'h0006, 16'h0010}, 64, 1'b1);
    check(nout, 38);
    check(st[17], 32'h1);
    wr(`MRF_OFF_CONFIG, 32'h0);
    frm(BC, 16'h0010, 64'h0, 64, 1'b1);
    check(nout, 64);
  endtask
  // Control frames, pause quanta and the pause count
  task automatic t_ctrl();
    frm(BC, 16'h8808, {16'h0002, 48'h0}, 64, 1'b1);
    check(st[8], 32'h1);
    wr(`MRF_OFF_CONFIG, 32'h4);
    frm(BC, 16'h8808, {16'h0002, 48'h0}, 64, 1'b1);
    check(st[8], 32'h0);
    wr(`MRF_OFF_CONFIG, 32'h0);
    frm(BC, 16'h8808, {16'h0001, 16'h1234, 32'h0}, 64, 1'b1);
    check(nq, 1);
    check(q, 32'h1234);
    check(st[9:8], 32'h3);
    frm(BC, 16'h8808, {16'h0001, 16'h1234, 32'h0}, 64, 1'b0);
    check(nq, 0);
    frm(BC, 16'h8808, {16'h0001, 16'h1234, 32'h0}, 68, 1'b1);
    check(nq, 0);
    wr(`MRF_OFF_CONFIG, 32'h8);
    frm(BC, 16'h8808, {16'h0001, 16'h00C3, 32'h0}, 64, 1'b1);
    check(st[8], 32'h0);
    rd(`MRF_OFF_PAUSE_COUNT);
    check(d, 32'h4);
    rd(`MRF_OFF_QUANTA);
    check(d, 32'h00C3);
    // Last frame was a forwarded pause: pause flag only
    rd(`MRF_OFF_STATUS);
    check(d, 32'h0000_0200);
  endtask
  // Verdict and end of run
  task automatic summarize();
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Reset for 8 cycles, then the scenarios
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_mcast();
    t_freeze();
    t_len();
    t_ctrl();
    summarize();
  end
endmodule
bind mrf_rx_frame_filter mrf_rx_checker i_mrf_rx_checker (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rx_valid_i(rx_valid_i),
  .rx_byte_i(rx_byte_i), .rx_crc_ok_i(rx_crc_ok_i), .out_valid_o(out_valid_o),
  .out_byte_o(out_byte_o), .out_end_o(out_end_o), .out_status_o(out_status_o),
  .quanta_valid_o(quanta_valid_o));

/* verilog/mrf_defs.svh */
// Offsets, field positions, reset values and frame constants of the rx frame filter
`ifndef MRF_DEFS_SVH
`define MRF_DEFS_SVH

// Register offsets (byte addresses)
`define MRF_OFF_CONFIG 8'h00
`define MRF_OFF_STATUS 8'h04
`define MRF_OFF_HASH_LO 8'h08
`define MRF_OFF_HASH_HI 8'h0C
`define MRF_OFF_PAUSE_COUNT 8'h10
`define MRF_OFF_QUANTA 8'h14

// Config register fields
`define MRF_CFG_HASH_SEL 0
`define MRF_CFG_PAD_STRIP 1
`define MRF_CFG_CTRL_ACCEPT 2
`define MRF_CFG_PAUSE_FORWARD 3
`define MRF_CFG_PAUSE_IGNORE 4
`define MRF_CFG_WIDTH 5
`define MRF_CFG_RESET 5'h00

// Frame status word fields
`define MRF_ST_LEN_ERR 1
`define MRF_ST_DISCARD 8
`define MRF_ST_PAUSE 9
`define MRF_ST_VLAN 16
`define MRF_ST_STACKED 17

// Frame constants
`define MRF_TYPE_LIMIT 16'h0600
`define MRF_TYPE_CTRL 16'h8808
`define MRF_TYPE_VLAN 16'h8100
`define MRF_OPC_PAUSE 16'h0001
`define MRF_HDR_PLAIN 16'h000E
`define MRF_HDR_VLAN 16'h0012
`define MRF_HDR_STACK 16'h0016
`define MRF_MINPAY_PLAIN 16'h002E
`define MRF_MINPAY_VLAN 16'h002A
`define MRF_MINPAY_STACK 16'h0026
`define MRF_FCS_BYTES 16'h0004
`define MRF_PAUSE_LEN 16'h0040
`define MRF_POS_MAX 16'hFFFF

`endif

/* verilog/mrf_pkg.sv */
// Types shared by the rx frame filter and its users
package mrf_pkg;

  // One received or forwarded octet with its frame markers
  typedef struct packed {
    logic sof;
    logic eof;
    logic [7:0] data;
  } mrf_byte_type;

  // Frame tracking state
  typedef enum logic {
    MRF_IDLE,
    MRF_FRAME
  } mrf_state_type;

endpackage

/* verilog/mrf_rx_frame_filter.sv */
// Receive frame filter: multicast hash, control/pause, VLAN tagging, pad strip
`timescale 1ns/1ps
`include "mrf_defs.svh"

module mrf_rx_frame_filter (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Received octets from the PHY side
  input wire logic rx_valid_i,
  input wire mrf_pkg::mrf_byte_type rx_byte_i,
  input wire logic rx_crc_ok_i,
  // Octets toward the receive FIFO
  output logic out_valid_o,
  output mrf_pkg::mrf_byte_type out_byte_o,
  output logic out_end_o,
  output logic [31:0] out_status_o,
  // Pause quanta toward the transmit path
  output logic quanta_valid_o,
  output logic [15:0] quanta_o
);
  import mrf_pkg::*;

  // Host-visible configuration
  logic [`MRF_CFG_WIDTH-1:0] cfg_r;
  logic hash_tab_r [0:63]; // Multicast acceptance table
  logic [31:0] pause_cnt_r; // Pause frames received
  logic [15:0] last_quanta_r; // Most recent delivered quanta
  logic [31:0] last_status_r; // Status of the last completed frame

  // Frame parsing state
  mrf_state_type state_r;
  logic [15:0] pos_r; // Index of the current octet in the frame
  logic [47:0] da_r; // Destination address, first octet in bits 7:0
  logic [15:0] type_r; // Outer length/type
  logic [15:0] opcode_r; // Control opcode or VLAN info
  logic [15:0] type2_r; // Field after first tag or quanta
  logic [15:0] ctype_r; // Client length/type after second tag
  logic mc_hit_r; // Sampled table entry for this frame

  // Decoded configuration bits
  logic hash_source_select;
  logic pad_strip;
  logic control_frame_accept;
  logic pause_forward;
  logic pause_ignore;

  // Classification of the frame in flight
  logic [15:0] pos_cur; // Position of the incoming octet
  logic [47:0] da_full; // Complete address at octet five
  logic [5:0] hash_code;
  logic is_vlan;
  logic is_stacked;
  logic is_ctrl;
  logic is_pause;
  logic [15:0] client;
  logic [15:0] hdr_len;
  logic [15:0] min_pay;
  logic is_len;
  logic strip_on;
  logic keep;
  logic is_mcast;
  logic is_bcast;
  logic reject;
  logic [15:0] frame_len;
  logic [15:0] exp_len;
  logic len_err;
  logic quanta_ok;
  logic [31:0] status_now;
  logic take;

  assign hash_source_select = cfg_r[`MRF_CFG_HASH_SEL];
  assign pad_strip = cfg_r[`MRF_CFG_PAD_STRIP];
  assign control_frame_accept = cfg_r[`MRF_CFG_CTRL_ACCEPT];
  assign pause_forward = cfg_r[`MRF_CFG_PAUSE_FORWARD];
  assign pause_ignore = cfg_r[`MRF_CFG_PAUSE_IGNORE];

  // An octet is consumed only when enabled and offered
  assign take = ce_i && rx_valid_i;

  // Start of frame restarts the position at zero
  assign pos_cur = rx_byte_i.sof ? 16'h0000 : pos_r;

  // Address as it stands once octet five arrives
  assign da_full = {rx_byte_i.data, da_r[39:0]};

  // Hash code from the complete address
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (hash_source_select) begin
        hash_code[i] = ^da_full[4*i +: 4];
      end else begin
        hash_code[i] = ^da_full[8*i +: 8];
      end
    end
  end

  // Tag and type decoding from captured fields
  always_comb begin
    is_vlan = (type_r == `MRF_TYPE_VLAN);
    is_stacked = is_vlan && (type2_r == `MRF_TYPE_VLAN);
    is_ctrl = (type_r == `MRF_TYPE_CTRL);
    is_pause = is_ctrl && (opcode_r == `MRF_OPC_PAUSE);
    if (is_stacked) begin
      client = ctype_r;
      hdr_len = `MRF_HDR_STACK;
      min_pay = `MRF_MINPAY_STACK;
    end else if (is_vlan) begin
      client = type2_r;
      hdr_len = `MRF_HDR_VLAN;
      min_pay = `MRF_MINPAY_VLAN;
    end else begin
      client = type_r;
      hdr_len = `MRF_HDR_PLAIN;
      min_pay = `MRF_MINPAY_PLAIN;
    end
    is_len = (client < `MRF_TYPE_LIMIT);
  end

  // Pad removal: drop octets past the declared payload
  always_comb begin
    strip_on = pad_strip && is_len && (client < min_pay);
    // Header octets always pass; fields are complete by then
    if (pos_cur < hdr_len || !strip_on) begin
      keep = 1'b1;
    end else begin
      keep = (pos_cur < hdr_len + client);
    end
  end

  // Address class and acceptance
  always_comb begin
    is_mcast = da_r[0];
    is_bcast = &da_r;
    reject = 1'b0;
    // Broadcast bypasses the table entirely
    if (is_mcast && !is_bcast && !mc_hit_r) begin
      reject = 1'b1;
    end
    // Other control opcodes need the accept bit
    if (is_ctrl && !is_pause && !control_frame_accept) begin
      reject = 1'b1;
    end
    // Pause frames end here unless forwarding is on
    if (is_pause && !pause_forward) begin
      reject = 1'b1;
    end
  end

  // End-of-frame length checks
  always_comb begin
    frame_len = pos_cur + 16'h0001;
    if (client > min_pay) begin
      exp_len = hdr_len + client + `MRF_FCS_BYTES;
    end else begin
      exp_len = hdr_len + min_pay + `MRF_FCS_BYTES;
    end
    len_err = is_len && (frame_len != exp_len);
    quanta_ok = is_pause && !pause_ignore && rx_crc_ok_i &&
                (frame_len == `MRF_PAUSE_LEN);
  end

  // Status word for the closing frame
  always_comb begin
    status_now = 32'h0000_0000;
    status_now[`MRF_ST_LEN_ERR] = len_err;
    status_now[`MRF_ST_DISCARD] = reject;
    status_now[`MRF_ST_PAUSE] = is_pause;
    status_now[`MRF_ST_VLAN] = is_vlan;
    status_now[`MRF_ST_STACKED] = is_stacked;
  end

  // Configuration register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= `MRF_CFG_RESET;
    end else if (ce_i && reg_wr_i && reg_addr_i == `MRF_OFF_CONFIG) begin
      cfg_r <= reg_wdata_i[`MRF_CFG_WIDTH-1:0];
    end
  end

  // Multicast table: host writes whole words, bit i of the low word is entry i, of the high word entry i+32
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 64; i++) begin
        hash_tab_r[i] <= 1'b0;
      end
    end else if (ce_i && reg_wr_i) begin
      for (int i = 0; i < 32; i++) begin
        if (reg_addr_i == `MRF_OFF_HASH_LO) begin
          hash_tab_r[i] <= reg_wdata_i[i];
        end
        if (reg_addr_i == `MRF_OFF_HASH_HI) begin
          hash_tab_r[i+32] <= reg_wdata_i[i];
        end
      end
    end
  end

  // Table lookup once the address is complete; the sampled entry
  // holds for the rest of the frame so later writes cannot tear it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mc_hit_r <= 1'b0;
    end else if (take && pos_cur == 16'h0005) begin
      mc_hit_r <= hash_tab_r[hash_code];
    end
  end

  // Frame tracking and octet position
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= MRF_IDLE;
      pos_r <= 16'h0000;
    end else if (take) begin
      if (rx_byte_i.eof) begin
        state_r <= MRF_IDLE;
      end else if (rx_byte_i.sof) begin
        state_r <= MRF_FRAME;
      end
      // Saturate so jumbo frames never wrap into the header range
      if (pos_cur != `MRF_POS_MAX) begin
        pos_r <= pos_cur + 16'h0001;
      end else begin
        pos_r <= pos_cur;
      end
    end
  end

  // Field capture; type, opcode and tag fields clear at start so stale tags never leak
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      da_r <= 48'h0000_0000_0000;
      type_r <= 16'h0000;
      opcode_r <= 16'h0000;
      type2_r <= 16'h0000;
      ctype_r <= 16'h0000;
    end else if (take && (rx_byte_i.sof || state_r == MRF_FRAME)) begin
      if (rx_byte_i.sof) begin
        type_r <= 16'h0000;
        opcode_r <= 16'h0000;
        type2_r <= 16'h0000;
        ctype_r <= 16'h0000;
      end
      unique case (pos_cur)
        16'h0000: da_r[7:0] <= rx_byte_i.data;
        16'h0001: da_r[15:8] <= rx_byte_i.data;
        16'h0002: da_r[23:16] <= rx_byte_i.data;
        16'h0003: da_r[31:24] <= rx_byte_i.data;
        16'h0004: da_r[39:32] <= rx_byte_i.data;
        16'h0005: da_r[47:40] <= rx_byte_i.data;
        // Length/type arrives most significant octet first
        16'h000C: type_r[15:8] <= rx_byte_i.data;
        16'h000D: type_r[7:0] <= rx_byte_i.data;
        16'h000E: opcode_r[15:8] <= rx_byte_i.data;
        16'h000F: opcode_r[7:0] <= rx_byte_i.data;
        16'h0010: type2_r[15:8] <= rx_byte_i.data;
        16'h0011: type2_r[7:0] <= rx_byte_i.data;
        16'h0014: ctype_r[15:8] <= rx_byte_i.data;
        16'h0015: ctype_r[7:0] <= rx_byte_i.data;
        default: ;
      endcase
    end
  end

  // Octet forwarding; rejected frames are flagged at the end for the FIFO to drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_byte_o <= '0;
    end else if (ce_i) begin
      out_valid_o <= rx_valid_i && keep;
      if (rx_valid_i) begin
        out_byte_o <= rx_byte_i;
      end
    end
  end

  // Frame end strobe with its status word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_end_o <= 1'b0;
      out_status_o <= 32'h0000_0000;
      last_status_r <= 32'h0000_0000;
    end else if (ce_i) begin
      out_end_o <= rx_valid_i && rx_byte_i.eof;
      if (rx_valid_i && rx_byte_i.eof) begin
        out_status_o <= status_now;
        last_status_r <= status_now;
      end
    end
  end

  // Pause quanta toward transmit; single clock, so no crossing is needed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quanta_valid_o <= 1'b0;
      quanta_o <= 16'h0000;
      last_quanta_r <= 16'h0000;
    end else if (ce_i) begin
      quanta_valid_o <= rx_valid_i && rx_byte_i.eof && quanta_ok;
      if (rx_valid_i && rx_byte_i.eof && quanta_ok) begin
        quanta_o <= type2_r;
        last_quanta_r <= type2_r;
      end
    end
  end

  // Pause statistics counter, counts every pause seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pause_cnt_r <= 32'h0000_0000;
    end else if (take && rx_byte_i.eof && is_pause) begin
      pause_cnt_r <= pause_cnt_r + 32'h0000_0001;
    end
  end

  // Register read, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      reg_rdata_o <= 32'h0000_0000;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          `MRF_OFF_CONFIG: reg_rdata_o <= {27'h0000000, cfg_r};
          `MRF_OFF_STATUS: reg_rdata_o <= last_status_r;
          `MRF_OFF_HASH_LO: begin
            for (int i = 0; i < 32; i++) begin
              reg_rdata_o[i] <= hash_tab_r[i];
            end
          end
          `MRF_OFF_HASH_HI: begin
            for (int i = 0; i < 32; i++) begin
              reg_rdata_o[i] <= hash_tab_r[i+32];
            end
          end
          `MRF_OFF_PAUSE_COUNT: reg_rdata_o <= pause_cnt_r;
          `MRF_OFF_QUANTA: reg_rdata_o <= {16'h0000, last_quanta_r};
          default: reg_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
